// File: fub_pkg.sv
package fub_pkg;
	// serial timing: 100 MHz clock, 38400 bit/s line
	localparam int unsigned CLK_HZ         = 100_000_000;
	localparam int unsigned BAUD_BPS       = 38_400;
	localparam int unsigned BIT_CYCLES     = CLK_HZ / BAUD_BPS;
	localparam int unsigned BIT_CNT_W      = 12;
	// frame and transfer geometry
	localparam int unsigned DATA_BITS      = 8;
	localparam int unsigned BLOCK_BYTES    = 8;
	localparam int unsigned RUN_BLOCKS     = 32;
	localparam int unsigned FIFO_DEPTH     = 16;
	localparam int unsigned FIFO_AW        = 4;
	localparam logic [4:0]  TX_THRESHOLD   = 5'h08;
	localparam logic [4:0]  FIFO_LVL_FULL  = 5'h10;
	localparam logic [5:0]  BLOCKS_RESET   = 6'h00;
	localparam logic [3:0]  FRAME_BITS     = 4'h9;

	// one byte moving along the data path
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} fub_byte_t;

	// run sequencing states
	typedef enum logic [2:0] {
		FUB_IDLE,
		FUB_FILL,
		FUB_WAIT,
		FUB_CPU,
		FUB_DRAIN
	} fub_state_t;

	// serial shifter states
	typedef enum logic [1:0] {
		FUB_TX_IDLE,
		FUB_TX_START,
		FUB_TX_DATA,
		FUB_TX_STOP
	} fub_tx_state_t;
endpackage : fub_pkg

// File: fub_tx_sequencer.sv
// Behaviour
// (RULE1) enable at low level raises fifo-empty request
// (RULE2) each request moves exactly one 8-byte block
// (RULE3) re-request whenever level falls to threshold
// (RULE4) after 32 blocks request goes to processor
// (RULE5) transmit-end pulses once last frame leaves
// (RULE6) one start edge launches one 256-byte run
// (RULE7) dedicated tx out, rx in, start pins
// (RULE8) 8N1 lsb first at 38400 bit/s
// (RULE9) transmit threshold fixed at eight bytes
// (RULE10) start taken on falling edge, unfiltered
// (RULE11) shift one byte per frame, idle high
module fub_tx_sequencer
	import fub_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       start_trigger_input,
	input  wire logic       serial_rx_in,
	input  wire logic [7:0] src_data,
	input  wire logic       src_valid,
	output logic            src_ready,
	output logic            tx_fifo_empty_request,
	output logic            cpu_empty_request,
	output logic            tx_end_interrupt,
	output logic            tx_complete,
	output logic            serial_tx_out,
	output logic            rx_sample
);

	////////////////////////////////////////////////////////////////////////
	// state
	fub_state_t    state;          // run sequencer
	fub_tx_state_t tx_state;       // shifter
	logic          start_prev;     // last start level
	logic [5:0]    blocks_done;    // blocks moved this run
	logic [3:0]    block_bytes;    // bytes of current block
	fub_byte_t     skid [2];       // two-entry input buffer
	logic          skid_rd;        // head entry index
	logic          skid_wr;        // tail entry index
	logic [7:0]    fifo_mem [FIFO_DEPTH];
	logic [FIFO_AW-1:0] fifo_rp;   // read pointer
	logic [FIFO_AW-1:0] fifo_wp;   // write pointer
	logic [4:0]    fifo_lvl;       // unsent byte count
	logic [BIT_CNT_W-1:0] bit_tmr; // cycles inside one bit
	logic [3:0]    bit_idx;        // data bit position
	logic [7:0]    shreg;          // transmit shift register

	////////////////////////////////////////////////////////////////////////
	// decode
	wire start_fall  = start_prev & ~start_trigger_input;  // RULE10
	wire at_thresh   = fifo_lvl <= TX_THRESHOLD;          // RULE9
	wire head_valid  = skid[skid_rd].valid;
	wire tail_free   = ~skid[skid_wr].valid;
	// a byte moves only on an edge where valid meets the registered ready
	wire take_in     = src_valid & src_ready & tail_free;
	wire fifo_push   = head_valid & (fifo_lvl != FIFO_LVL_FULL)
	                   & (state == FUB_FILL);
	wire fifo_pop    = (tx_state == FUB_TX_IDLE) & (fifo_lvl != 5'h00);
	wire bit_end     = bit_tmr == BIT_CNT_W'(BIT_CYCLES - 1);
	wire block_end   = fifo_push & (block_bytes == 4'(BLOCK_BYTES - 1));
	wire run_end     = block_end & (blocks_done == 6'(RUN_BLOCKS - 1));
	wire line_idle   = (tx_state == FUB_TX_IDLE) & (fifo_lvl == 5'h00);
	wire [4:0] next_fifo_lvl = fifo_lvl + {4'h0, fifo_push}
	                           - {4'h0, fifo_pop};
	// buffer occupancy now and after this edge
	wire [1:0] skid_cnt      = {1'b0, skid[0].valid}
	                           + {1'b0, skid[1].valid};
	wire [1:0] next_skid_cnt = skid_cnt + {1'b0, take_in}
	                           - {1'b0, fifo_push};

	////////////////////////////////////////////////////////////////////////
	// two-entry buffer in front of the fifo
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_skid
			always_ff @(posedge clk) begin
				if (rst) begin
					skid[gi] <= '0;
				end else if (take_in && skid_wr == 1'(gi)) begin
					skid[gi] <= '{valid: 1'b1, data: src_data};
				end else if (fifo_push && skid_rd == 1'(gi)) begin
					skid[gi].valid <= 1'b0;
				end
			end
		end
	endgenerate

	// buffer pointers and registered ready toward the source
	always_ff @(posedge clk) begin
		if (rst) begin
			skid_rd   <= 1'b0;
			skid_wr   <= 1'b0;
			src_ready <= 1'b0;
		end else begin
			skid_rd   <= skid_rd ^ fifo_push;
			skid_wr   <= skid_wr ^ take_in;
			// promise a slot only if one stays free after this edge, so
			// both entries fill while the fifo stalls and no byte is lost
			src_ready <= next_skid_cnt < 2'h2;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit fifo storage (written as transmit_fifo_data_reg)
	always_ff @(posedge clk) begin
		if (fifo_push) begin
			fifo_mem[fifo_wp] <= skid[skid_rd].data;
		end
	end

	// fifo pointers and level
	always_ff @(posedge clk) begin
		if (rst) begin
			fifo_rp  <= '0;
			fifo_wp  <= '0;
			fifo_lvl <= '0;
		end else begin
			fifo_wp  <= fifo_wp + FIFO_AW'(fifo_push);
			fifo_rp  <= fifo_rp + FIFO_AW'(fifo_pop);
			fifo_lvl <= next_fifo_lvl;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// run sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			state       <= FUB_IDLE;
			start_prev  <= 1'b1;
			blocks_done <= BLOCKS_RESET;
			block_bytes <= '0;
			tx_complete <= 1'b1;
		end else begin
			start_prev <= start_trigger_input;
			case (state)
				FUB_IDLE: begin
					// a new edge is ignored until the run completes
					if (start_fall) begin  // RULE6
						blocks_done <= BLOCKS_RESET;
						tx_complete <= 1'b0;
						state       <= FUB_WAIT;
					end
				end
				FUB_WAIT: begin
					if (at_thresh) begin  // RULE1 RULE3
						state <= FUB_FILL;
					end
				end
				FUB_FILL: begin
					if (fifo_push) begin  // RULE2
						block_bytes <= block_bytes + 4'h1;
					end
					if (block_end) begin
						block_bytes <= '0;
						blocks_done <= blocks_done + 6'h01;
						state <= run_end ? FUB_CPU : FUB_WAIT;  // RULE4
					end
				end
				FUB_CPU: begin
					// processor handler swaps empty for end interrupt
					state <= FUB_DRAIN;  // RULE4
				end
				FUB_DRAIN: begin
					if (line_idle) begin  // RULE5
						tx_complete <= 1'b1;
						state       <= FUB_IDLE;
					end
				end
				default: state <= FUB_IDLE;
			endcase
		end
	end

	// request outputs follow the sequencer one cycle late
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_fifo_empty_request <= 1'b0;
			cpu_empty_request     <= 1'b0;
			tx_end_interrupt      <= 1'b0;
		end else begin
			tx_fifo_empty_request <= state == FUB_FILL;  // RULE1 RULE3
			cpu_empty_request     <= state == FUB_CPU;   // RULE4
			tx_end_interrupt <= (state == FUB_DRAIN) & line_idle;  // RULE5
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serial shifter, 8N1 lsb first
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_state      <= FUB_TX_IDLE;
			bit_tmr       <= '0;
			bit_idx       <= '0;
			shreg         <= '0;
			serial_tx_out <= 1'b1;
		end else begin
			bit_tmr <= bit_end ? '0 : bit_tmr + BIT_CNT_W'(1);
			case (tx_state)
				FUB_TX_IDLE: begin
					serial_tx_out <= 1'b1;  // RULE11
					bit_tmr       <= '0;
					if (fifo_pop) begin  // RULE11
						shreg         <= fifo_mem[fifo_rp];
						serial_tx_out <= 1'b0;
						tx_state      <= FUB_TX_START;
					end
				end
				FUB_TX_START: begin
					if (bit_end) begin
						serial_tx_out <= shreg[0];  // RULE8
						bit_idx       <= 4'h1;
						tx_state      <= FUB_TX_DATA;
					end
				end
				FUB_TX_DATA: begin
					if (bit_end) begin
						if (bit_idx == 4'(DATA_BITS)) begin
							serial_tx_out <= 1'b1;  // RULE8
							tx_state      <= FUB_TX_STOP;
						end else begin
							serial_tx_out <= shreg[bit_idx[2:0]];
							bit_idx       <= bit_idx + 4'h1;
						end
					end
				end
				FUB_TX_STOP: begin
					if (bit_end) begin
						tx_state <= FUB_TX_IDLE;
					end
				end
				default: tx_state <= FUB_TX_IDLE;
			endcase
		end
	end

	// receive pin is registered and handed on; no receive path here
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_sample <= 1'b1;
		end else begin
			rx_sample <= serial_rx_in;  // RULE7
		end
	end

endmodule : fub_tx_sequencer

// File: fub_tx_sequencer_sva.sv
module fub_tx_sequencer_sva
	import fub_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       start_trigger_input,
	input wire logic       serial_rx_in,
	input wire logic [7:0] src_data,
	input wire logic       src_valid,
	input wire logic       src_ready,
	input wire logic       tx_fifo_empty_request,
	input wire logic       cpu_empty_request,
	input wire logic       tx_end_interrupt,
	input wire logic       tx_complete,
	input wire logic       serial_tx_out,
	input wire logic       rx_sample
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	int   len;  // samples the line has stood at one level
	logic last; // line level one sample ago
	// only low runs are timed: the first high run after reset is arbitrary
	always_ff @(posedge clk) begin
		last <= rst | serial_tx_out;
		len  <= (rst || serial_tx_out != last) ? 1 : len + 1;
	end
	sequence s_go;
		$fell(start_trigger_input) && tx_complete;
	endsequence
	sequence s_end;
		tx_complete && serial_tx_out ##1 !tx_end_interrupt;
	endsequence
	property p_go;
		s_go |=> !tx_complete ##[1:3] tx_fifo_empty_request;
	endproperty
	property p_fall;
		$fell(tx_complete) |->
			$past(start_trigger_input, 2) && !$past(start_trigger_input);
	endproperty
	property p_idle;
		tx_complete |-> !tx_fifo_empty_request && !cpu_empty_request;
	endproperty
	property p_cpu;
		cpu_empty_request |=>
			(!cpu_empty_request && !tx_fifo_empty_request) [*8];
	endproperty
	property p_end;
		tx_end_interrupt |-> s_end;
	endproperty
	property p_done;
		$rose(tx_complete) |-> tx_end_interrupt;
	endproperty
	property p_low;
		!last && serial_tx_out |-> len % BIT_CYCLES == 0;
	endproperty
	property p_frame;
		$fell(serial_tx_out) |-> !tx_complete;
	endproperty
	a_go: assert property (p_go) else $error("no run");
	a_fall: assert property (p_fall) else $error("bad start");
	a_idle: assert property (p_idle) else $error("idle req");
	a_cpu: assert property (p_cpu) else $error("cpu req");
	a_end: assert property (p_end) else $error("bad end");
	a_done: assert property (p_done) else $error("no end");
	a_low: assert property (p_low) else $error("bit time");
	a_frame: assert property (p_frame) else $error("idle frame");
endmodule : fub_tx_sequencer_sva
bind fub_tx_sequencer fub_tx_sequencer_sva u_sva (.clk, .rst,
	.start_trigger_input, .serial_rx_in, .src_data, .src_valid, .src_ready,
	.tx_fifo_empty_request, .cpu_empty_request, .tx_end_interrupt,
	.tx_complete, .serial_tx_out, .rx_sample);

// File: fub_rx_model.sv
module fub_rx_model
	import fub_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       line,
	output logic      [7:0] rx_byte,
	output logic            stop_ok,
	output int              n_rx
);
	timeunit 1ns;
	timeprecision 1ps;
	// far receiver: finds the start edge, then samples each data bit and the stop bit mid-way
	initial begin
		n_rx = 0;
		rx_byte = 8'h00;
		stop_ok = 1'b0;
		forever begin
			@(negedge line);
			repeat (BIT_CYCLES / 2) @(posedge clk);
			for (int i = 0; i < 9; i++) begin
				repeat (BIT_CYCLES) @(posedge clk);
				if (i < 8) rx_byte = {line, rx_byte[7:1]};
				else stop_ok = line;
			end
			n_rx++;
		end
	end
endmodule : fub_rx_model

// File: tb_fub_tx_sequencer.sv
module tb_fub_tx_sequencer
	import fub_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk, rst, start_trigger_input, serial_rx_in, src_valid;
	logic [7:0] src_data, rx_byte;
	logic       src_ready, tx_fifo_empty_request, cpu_empty_request;
	logic       tx_end_interrupt, tx_complete, serial_tx_out, rx_sample;
	logic       stop_ok, req_q;
	int         n_rx, n_req, w, mismatches, n_tests;
	fub_tx_sequencer u_fub_tx_sequencer (.clk, .rst, .start_trigger_input,
		.serial_rx_in, .src_data, .src_valid, .src_ready,
		.tx_fifo_empty_request, .cpu_empty_request, .tx_end_interrupt,
		.tx_complete, .serial_tx_out, .rx_sample);
	fub_rx_model u_fub_rx_model (.clk, .line(serial_tx_out), .rx_byte,
		.stop_ok, .n_rx);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// counts request rises, i.e. blocks asked for
	always @(posedge clk) begin
		if (tx_fifo_empty_request === 1'b1 && req_q !== 1'b1) n_req++;
		req_q <= tx_fifo_empty_request;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task end_sim;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_sim
	task t_reset;
		repeat (8) @(posedge clk);
		#1 chk(8'(src_ready), 8'h00);
		chk(8'(tx_complete), 8'h01);
		chk(8'(serial_tx_out), 8'h01);
		rst = 1'b0;
		serial_rx_in = 1'b0;
		@(posedge clk);
		#1 chk(8'(rx_sample), 8'h00);
		serial_rx_in = 1'b1;
	endtask : t_reset
	task t_start;
		start_trigger_input = 1'b0;
		@(posedge clk);
		#1 chk(8'(tx_complete), 8'h00);
		for (w = 0; w < 20 && tx_fifo_empty_request !== 1'b1; w++) begin
			@(posedge clk);
			#1;
		end
		chk(8'(tx_fifo_empty_request), 8'h01);
		start_trigger_input = 1'b1;
	endtask : t_start
	// two blocks fit the fifo, two more bytes stall in the buffer
	task t_fill;
		for (int i = 0; i < 18; i++) begin
			src_data = 8'(i) + 8'h1b;
			src_valid = 1'b1;
			w = 0;
			do begin
				@(posedge clk);
				w++;
			end while (src_ready !== 1'b1 && w < 300);
			#1 chk(8'(w < 300), 8'h01);
		end
		src_valid = 1'b0;
		repeat (4) @(posedge clk);
		#1 chk(8'(src_ready), 8'h00);
		chk(8'(tx_fifo_empty_request), 8'h00);
		chk(8'(n_req), 8'h02);
	endtask : t_fill
	// a start edge in mid-run is ignored; first frames decoded
	task t_frames;
		start_trigger_input = 1'b0;
		repeat (3) @(posedge clk);
		#1 chk(8'(tx_complete), 8'h00);
		chk(8'(n_req), 8'h02);
		start_trigger_input = 1'b1;
		for (int k = 0; k < 2; k++) begin
			for (w = 0; w < 30000 && n_rx <= k; w++) begin
				@(posedge clk);
				#1;
			end
			chk(rx_byte, 8'(k) + 8'h1b);
			chk(8'(stop_ok), 8'h01);
			chk(8'(cpu_empty_request), 8'h00);
			chk(8'(tx_end_interrupt), 8'h00);
		end
	endtask : t_frames
	initial begin
		rst = 1'b1;
		start_trigger_input = 1'b1;
		serial_rx_in = 1'b1;
		src_valid = 1'b0;
		src_data = 8'h00;
		t_reset;
		t_start;
		t_fill;
		t_frames;
		end_sim;
	end
	// hang guard: the tests need about 51000 cycles
	initial begin
		repeat (70000) @(posedge clk);
		mismatches++;
		end_sim;
	end
endmodule : tb_fub_tx_sequencer
